// ==== shared/sftc_cfg.svh ====
// Constants for the serial FIFO trigger control block: addresses, field positions, reset values, trigger figures.
// Assumes a 16-entry transmit and receive FIFO whose fill counts arrive from the data path each clock.
// How it works
// RULE1: A 16-bit FIFO control register, readable and writable by the CPU at any time.
// RULE2: Reset clears the whole FIFO control register to zero.
// RULE3: Bits 15 to 11 always read zero; software writes zero there.
// RULE4: RTS goes high once receive fill count exceeds the selected flow trigger.
// RULE5: Channel 2 has no flow trigger field; those bits read zero.
// RULE6: Receive-data-full flag sets when receive count exceeds the receive trigger.
// RULE7: Receive trigger codes give 1,4,8,14 asynchronous and 1,2,8,14 synchronous.
// RULE8: Transmit-empty flag sets when transmit count falls to the selected trigger.
// RULE9: Transmit FIFO holds sixteen; free space at flag is 8,12,14,16.
// RULE10: RTS follows receive fill only while modem control is enabled.
// RULE11: RTS stays low while enabled and fill is at or below trigger.
`ifndef SFTC_CFG_SVH
`define SFTC_CFG_SVH

// Register byte addresses on the APB
`define SFTC_ADDR_CTRL 12'h000
`define SFTC_ADDR_STAT 12'h004
`define SFTC_ADDR_MASK 12'h008
`define SFTC_ADDR_COUNT 12'h00c

// Control register reset value and writable bits per channel
`define SFTC_CTRL_RESET 16'h0000
`define SFTC_CTRL_WMASK 16'h07ff
`define SFTC_CTRL_WMASK_CH2 16'h00f7
`define SFTC_NO_FLOW_CHANNEL 2
`define SFTC_RSVD_HI 15
`define SFTC_RSVD_LO 11

// Control field positions
`define SFTC_FLOW_HI 10
`define SFTC_FLOW_LO 8
`define SFTC_RX_HI 7
`define SFTC_RX_LO 6
`define SFTC_TX_HI 5
`define SFTC_TX_LO 4
`define SFTC_MCE_BIT 3

// Status and mask bit positions, and their reset value
`define SFTC_ST_TX_FIFO_EMPTY_FLAG 0
`define SFTC_ST_RDF 1
`define SFTC_ST_RESET 2'h0

// Count register fields
`define SFTC_CNT_TX_HI 12
`define SFTC_CNT_TX_LO 8
`define SFTC_CNT_RX_HI 4
`define SFTC_CNT_RX_LO 0

// Flow trigger values for codes 000 to 111
`define SFTC_FLOW_T0 5'h0f
`define SFTC_FLOW_T1 5'h01
`define SFTC_FLOW_T2 5'h04
`define SFTC_FLOW_T3 5'h06
`define SFTC_FLOW_T4 5'h08
`define SFTC_FLOW_T5 5'h0a
`define SFTC_FLOW_T6 5'h0c
`define SFTC_FLOW_T7 5'h0e

// Receive trigger values for codes 00 to 11
`define SFTC_RX_T0 5'h01
`define SFTC_RX_T1_ASYNC 5'h04
`define SFTC_RX_T1_SYNC 5'h02
`define SFTC_RX_T2 5'h08
`define SFTC_RX_T3 5'h0e

// Transmit trigger values for codes 00 to 11, and FIFO depth
`define SFTC_TX_T0 5'h08
`define SFTC_TX_T1 5'h04
`define SFTC_TX_T2 5'h02
`define SFTC_TX_T3 5'h00
`define SFTC_FIFO_DEPTH 5'h10

`endif

// ==== shared/sftc_pkg.sv ====
// Types shared by the serial FIFO trigger control files.
// Assumes the constants header is included where figures are needed.
package sftc_pkg;
    typedef logic [4:0] sftc_count_t;
    typedef logic [15:0] sftc_ctrl_t;
    typedef enum logic {SFTC_ASYNC, SFTC_SYNC} sftc_mode_e;
endpackage

// ==== hdl/sftc_thresholds.sv ====
// Trigger decoder: turns the three control fields into fill-count thresholds.
// Assumes the fields come from a register, so the outputs are steady between writes.
`include "sftc_cfg.svh"

module sftc_thresholds (
    input wire logic [2:0] flow_code,
    input wire logic [1:0] rx_code,
    input wire logic [1:0] tx_code,
    input wire sftc_pkg::sftc_mode_e mode,
    output sftc_pkg::sftc_count_t flow_thr,
    output sftc_pkg::sftc_count_t rx_thr,
    output sftc_pkg::sftc_count_t tx_thr
);
    import sftc_pkg::*;

    // RULE4 flow trigger decode
    always_comb begin
        unique case (flow_code)
            3'h0: flow_thr = `SFTC_FLOW_T0;
            3'h1: flow_thr = `SFTC_FLOW_T1;
            3'h2: flow_thr = `SFTC_FLOW_T2;
            3'h3: flow_thr = `SFTC_FLOW_T3;
            3'h4: flow_thr = `SFTC_FLOW_T4;
            3'h5: flow_thr = `SFTC_FLOW_T5;
            3'h6: flow_thr = `SFTC_FLOW_T6;
            3'h7: flow_thr = `SFTC_FLOW_T7;
        endcase
    end

    // RULE7 mode-dependent receive trigger
    always_comb begin
        unique case (rx_code)
            2'h0: rx_thr = `SFTC_RX_T0;
            2'h1: rx_thr = (mode == SFTC_SYNC) ? `SFTC_RX_T1_SYNC : `SFTC_RX_T1_ASYNC;
            2'h2: rx_thr = `SFTC_RX_T2;
            2'h3: rx_thr = `SFTC_RX_T3;
        endcase
    end

    // RULE8 transmit trigger decode
    always_comb begin
        unique case (tx_code)
            2'h0: tx_thr = `SFTC_TX_T0;
            2'h1: tx_thr = `SFTC_TX_T1;
            2'h2: tx_thr = `SFTC_TX_T2;
            2'h3: tx_thr = `SFTC_TX_T3;
        endcase
    end
endmodule // sftc_thresholds

// ==== hdl/sftc_top.sv ====
// Serial FIFO trigger control: APB registers, RTS flow control, status flags and interrupt.
// Assumes fill counts arrive synchronous to ref_clk from the FIFO data path, 0 to 16 each.
`include "sftc_cfg.svh"

module sftc_top #(
    parameter int CHANNEL = 0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sftc_pkg::sftc_count_t rx_count,
    input wire sftc_pkg::sftc_count_t tx_count,
    input wire sftc_pkg::sftc_mode_e mode,
    output logic rts_n,
    output logic irq
);
    import sftc_pkg::*;

    sftc_ctrl_t fifo_control;
    sftc_ctrl_t next_fifo_control;
    logic [1:0] serial_status;
    logic [1:0] next_serial_status;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_rts_n;
    logic next_irq;
    logic xfer_done;
    logic ctrl_wr;
    logic stat_wr;
    logic mask_wr;
    logic addr_hit;
    logic modem_ctrl_enable;
    logic rx_data_full_cond;
    logic tx_fifo_empty_cond;
    logic [1:0] flag_set;
    logic [1:0] flag_clear;
    sftc_ctrl_t wr_mask;
    sftc_count_t flow_thr;
    sftc_count_t rx_thr;
    sftc_count_t tx_thr;

    // Channel 2 keeps neither the flow trigger nor modem enable writable
    assign wr_mask = (CHANNEL == `SFTC_NO_FLOW_CHANNEL) ? `SFTC_CTRL_WMASK_CH2 : `SFTC_CTRL_WMASK;

    // Completion edge of an APB access: the only edge where writes land
    assign xfer_done = psel && penable && pready;

    // Write strobes share one decode, so every register sees the same completion edge
    function automatic logic reg_write(input logic done, input logic wr, input logic [11:0] addr,
        input logic [11:0] match);
        return done && wr && addr == match;
    endfunction

    assign ctrl_wr = reg_write(xfer_done, pwrite, paddr, `SFTC_ADDR_CTRL);
    assign stat_wr = reg_write(xfer_done, pwrite, paddr, `SFTC_ADDR_STAT);
    assign mask_wr = reg_write(xfer_done, pwrite, paddr, `SFTC_ADDR_MASK);

    // Address decode for all mapped registers
    always_comb begin
        unique case (paddr)
            `SFTC_ADDR_CTRL, `SFTC_ADDR_STAT, `SFTC_ADDR_MASK, `SFTC_ADDR_COUNT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign modem_ctrl_enable = fifo_control[`SFTC_MCE_BIT];

    sftc_thresholds u_thresholds (
        .flow_code(fifo_control[`SFTC_FLOW_HI:`SFTC_FLOW_LO]),
        .rx_code(fifo_control[`SFTC_RX_HI:`SFTC_RX_LO]),
        .tx_code(fifo_control[`SFTC_TX_HI:`SFTC_TX_LO]),
        .mode(mode),
        .flow_thr(flow_thr),
        .rx_thr(rx_thr),
        .tx_thr(tx_thr)
    );

    // RULE6 receive threshold compare
    assign rx_data_full_cond = rx_count > rx_thr;
    // RULE8 transmit threshold compare, at or below so code 11 means empty
    // RULE9 sets with 8, 12, 14 or 16 entries free
    assign tx_fifo_empty_cond = tx_count <= tx_thr;

    // APB answer: one wait state so prdata and pready come from flops
    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !addr_hit;
        next_prdata = 32'h0;
        if (psel && penable && !pready && !pwrite) begin
            unique case (paddr)
                // RULE3 reserved bits are held zero in the register itself
                `SFTC_ADDR_CTRL: next_prdata[15:0] = fifo_control;
                `SFTC_ADDR_STAT: next_prdata[1:0] = serial_status;
                `SFTC_ADDR_MASK: next_prdata[1:0] = irq_mask;
                `SFTC_ADDR_COUNT: begin
                    next_prdata[`SFTC_CNT_TX_HI:`SFTC_CNT_TX_LO] = tx_count;
                    next_prdata[`SFTC_CNT_RX_HI:`SFTC_CNT_RX_LO] = rx_count;
                end
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // RULE1 control register write; reserved and absent bits are masked off
    always_comb begin
        next_fifo_control = fifo_control;
        if (ctrl_wr) begin
            // RULE5 channel 2 drops flow trigger writes
            next_fifo_control = pwdata[15:0] & wr_mask;
        end
        next_irq_mask = irq_mask;
        if (mask_wr) begin
            next_irq_mask = pwdata[1:0];
        end
    end

    // RULE2 power-on clear of the control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifo_control <= `SFTC_CTRL_RESET;
            irq_mask <= `SFTC_ST_RESET;
        end else begin
            fifo_control <= next_fifo_control;
            irq_mask <= next_irq_mask;
        end
    end

    // Sticky flags: a set in the clearing cycle wins so no event is lost
    always_comb begin
        flag_set = 2'h0;
        flag_set[`SFTC_ST_RDF] = rx_data_full_cond;
        flag_set[`SFTC_ST_TX_FIFO_EMPTY_FLAG] = tx_fifo_empty_cond;
        flag_clear = 2'h0;
        if (stat_wr) begin
            flag_clear = pwdata[1:0];
        end
        next_serial_status = (serial_status & ~flag_clear) | flag_set;
        next_irq = |(next_serial_status & next_irq_mask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_status <= `SFTC_ST_RESET;
            irq <= 1'b0;
        end else begin
            serial_status <= next_serial_status;
            irq <= next_irq;
        end
    end

    // RTS flow control; with modem control off the pin rests low
    always_comb begin
        next_rts_n = 1'b0;
        // RULE10 only under modem control
        if (modem_ctrl_enable) begin
            // RULE4 high above trigger, RULE11 low at or below
            next_rts_n = rx_count > flow_thr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rts_n <= 1'b0;
        end else begin
            rts_n <= next_rts_n;
        end
    end

    // Checks, all in the ref_clk domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_ctrl_write: assert property ( // RULE1
        xfer_done && pwrite && paddr == `SFTC_ADDR_CTRL |=> fifo_control == ($past(pwdata[15:0]) & wr_mask))
        else $error("control write not stored");

    chk_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0) // RULE2
        rst |=> fifo_control == `SFTC_CTRL_RESET && !rts_n && !irq)
        else $error("reset did not clear control");

    chk_rsvd_zero: assert property ( // RULE3
        fifo_control[`SFTC_RSVD_HI:`SFTC_RSVD_LO] == 5'h00)
        else $error("reserved control bits nonzero");

    chk_rts_high: assert property ( // RULE4
        modem_ctrl_enable && rx_count > flow_thr |=> rts_n)
        else $error("rts not raised above trigger");

    chk_ch2_flow: assert property ( // RULE5
        CHANNEL == `SFTC_NO_FLOW_CHANNEL |-> fifo_control[`SFTC_FLOW_HI:`SFTC_FLOW_LO] == 3'h0)
        else $error("channel 2 flow field nonzero");

    chk_rdf_set: assert property ( // RULE6
        rx_count > rx_thr |=> serial_status[`SFTC_ST_RDF])
        else $error("receive full flag missed");

    chk_rx_sync_code: assert property ( // RULE7
        fifo_control[`SFTC_RX_HI:`SFTC_RX_LO] == 2'h1 |-> rx_thr == (mode == SFTC_SYNC ? 5'h02 : 5'h04))
        else $error("receive trigger decode wrong");

    chk_tx_fifo_empty_flag_set: assert property ( // RULE8
        tx_count <= tx_thr |=> serial_status[`SFTC_ST_TX_FIFO_EMPTY_FLAG])
        else $error("transmit empty flag missed");

    chk_tx_space: assert property ( // RULE9
        $rose(serial_status[`SFTC_ST_TX_FIFO_EMPTY_FLAG]) |-> `SFTC_FIFO_DEPTH - $past(tx_count) >= `SFTC_FIFO_DEPTH - $past(tx_thr))
        else $error("transmit free space short at flag");

    chk_rts_idle: assert property ( // RULE10
        !modem_ctrl_enable |=> !rts_n)
        else $error("rts moved without modem control");

    chk_rts_low: assert property ( // RULE11
        modem_ctrl_enable && rx_count <= flow_thr |=> !rts_n)
        else $error("rts high at or below trigger");

    chk_irq_level: assert property (
        irq == |(serial_status & irq_mask))
        else $error("interrupt disagrees with status");

    // Bus answer: one-cycle pready, error only with it, data idle at zero
    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held over one cycle");

    chk_err_ready: assert property (
        pslverr |-> pready)
        else $error("pslverr without pready");

    chk_unmapped_err: assert property (
        xfer_done && !addr_hit |-> pslverr)
        else $error("unmapped access without error");

    chk_rdata_idle: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data outside completion");

    chk_ctrl_read: assert property ( // RULE1
        xfer_done && !pwrite && paddr == `SFTC_ADDR_CTRL |-> prdata == {16'h0, fifo_control})
        else $error("control read mismatch");

    chk_rsvd_read: assert property ( // RULE3
        xfer_done && !pwrite && paddr == `SFTC_ADDR_CTRL |-> prdata[`SFTC_RSVD_HI:`SFTC_RSVD_LO] == 5'h00)
        else $error("reserved control bits read nonzero");

    chk_count_read: assert property (
        xfer_done && !pwrite && paddr == `SFTC_ADDR_COUNT
            |-> prdata[`SFTC_CNT_TX_HI:`SFTC_CNT_TX_LO] == $past(tx_count)
            && prdata[`SFTC_CNT_RX_HI:`SFTC_CNT_RX_LO] == $past(rx_count))
        else $error("count read mismatch");

    chk_mask_write: assert property (
        mask_wr |=> irq_mask == $past(pwdata[1:0]))
        else $error("mask write not stored");

    chk_flow_default: assert property ( // RULE4
        fifo_control[`SFTC_FLOW_HI:`SFTC_FLOW_LO] == 3'h0 |-> flow_thr == 5'h0f)
        else $error("flow trigger default decode wrong");

    chk_ch2_rts: assert property ( // RULE5
        CHANNEL == `SFTC_NO_FLOW_CHANNEL |-> !rts_n)
        else $error("channel 2 rts moved");

    chk_rdf_quiet: assert property ( // RULE6
        !serial_status[`SFTC_ST_RDF] && rx_count <= rx_thr |=> !serial_status[`SFTC_ST_RDF])
        else $error("receive full flag set early");

    chk_rdf_sticky: assert property ( // RULE6
        serial_status[`SFTC_ST_RDF] && !(stat_wr && pwdata[`SFTC_ST_RDF]) |=> serial_status[`SFTC_ST_RDF])
        else $error("receive full flag lost");

    chk_tx_fifo_empty_flag_quiet: assert property ( // RULE8
        !serial_status[`SFTC_ST_TX_FIFO_EMPTY_FLAG] && tx_count > tx_thr |=> !serial_status[`SFTC_ST_TX_FIFO_EMPTY_FLAG])
        else $error("transmit empty flag set early");

    chk_tx_decode: assert property ( // RULE8
        fifo_control[`SFTC_TX_HI:`SFTC_TX_LO] == 2'h3 |-> tx_thr == 5'h00)
        else $error("transmit trigger decode wrong");

    // Main scenarios the bench is meant to reach
    cov_rts_raise: cover property (modem_ctrl_enable ##1 $rose(rts_n));
    cov_rdf_clear: cover property (serial_status[`SFTC_ST_RDF] ##1 !serial_status[`SFTC_ST_RDF]);
    cov_irq_rise: cover property ($rose(irq));
    cov_bad_addr: cover property (xfer_done && pslverr);
    cov_tx_fifo_empty_flag_rise: cover property ($rose(serial_status[`SFTC_ST_TX_FIFO_EMPTY_FLAG]));
endmodule // sftc_top

// ==== dv/sftc_peer.sv ====
// Far-side model: a remote sender that fills the receive FIFO and honours the RTS pin.
// Assumes the bench sets a fill target; the receive side drains it one entry a clock.
module sftc_peer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rts_n,
    input wire logic [4:0] target,
    output sftc_pkg::sftc_count_t rx_count
);
    import sftc_pkg::*;

    // One entry a clock; the sender sees RTS a clock late, so it may overrun by one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_count <= '0;
        end else if (rx_count < target && !rts_n) begin
            rx_count <= rx_count + 5'h01;
        end else if (rx_count > target) begin
            rx_count <= rx_count - 5'h01;
        end
    end
endmodule // sftc_peer

// ==== dv/testbench.sv ====
// Self-checking bench: APB register tests, RTS flow control, flags and interrupt.
// Assumes the peer model drives the receive fill and the bench drives the transmit fill.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sftc_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, prdata_2, rd, rd_2;
    logic pready, pready_2, pslverr, pslverr_2, rts_n, rts_n_2, irq, irq_2, err;
    logic [4:0] target = 5'h00;
    sftc_count_t rx_count;
    sftc_count_t tx_count = 5'h10;
    sftc_mode_e mode = SFTC_ASYNC;
    int miscompares = 0;
    int total_checks = 0;
    int flow_thr[8] = '{15, 1, 4, 6, 8, 10, 12, 14};
    int rx_thr[2][4] = '{'{1, 4, 8, 14}, '{1, 2, 8, 14}};
    int tx_thr[4] = '{8, 4, 2, 0};

    // Clock at 25 MHz
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    sftc_top #(.CHANNEL(0)) i_sftc_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_count(rx_count), .tx_count(tx_count), .mode(mode), .rts_n(rts_n), .irq(irq));
    // Channel without flow trigger shares the bus; only its read data and rts_n_2 are looked at
    sftc_top #(.CHANNEL(2)) i_sftc_top_2 (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_2), .pready(pready_2),
        .pslverr(pslverr_2), .rx_count(rx_count), .tx_count(tx_count), .mode(mode), .rts_n(rts_n_2),
        .irq(irq_2));
    sftc_peer i_sftc_peer (.ref_clk(ref_clk), .rst(rst), .rts_n(rts_n), .target(target), .rx_count(rx_count));

    // One APB transfer; a slave that never answers is left to the watchdog
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rd_2 = prdata_2;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Long enough for the peer to cross the whole FIFO
    task automatic settle;
        repeat (24) @(posedge ref_clk);
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'hffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h07ff);
        chk(rd_2, 32'h00f7);
        apb(1'b1, 12'h000, 32'h0);
        target <= 5'h10;
        settle;
        chk(rts_n, 1'b0);
        target <= 5'h00;
        settle;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h000, (i << 8) | 32'h8);
            target <= 5'h10;
            settle;
            chk(rts_n, 1'b1);
            chk(rx_count, (flow_thr[i] + 2 > 16) ? 16 : flow_thr[i] + 2);
            chk(rts_n_2, 1'b0);
            target <= 5'h00;
            settle;
            chk(rts_n, 1'b0);
        end
        apb(1'b1, 12'h000, 32'h0);
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                mode <= sftc_mode_e'(m);
                apb(1'b1, 12'h000, c << 6);
                target <= rx_thr[m][c][4:0];
                settle;
                apb(1'b1, 12'h004, 32'h3);
                apb(1'b0, 12'h004, 32'h0);
                chk(rd[1], 1'b0);
                target <= rx_thr[m][c][4:0] + 5'h01;
                settle;
                apb(1'b0, 12'h004, 32'h0);
                chk(rd[1], 1'b1);
            end
        end
        target <= 5'h00;
        settle;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h000, c << 4);
            tx_count <= tx_thr[c][4:0] + 5'h01;
            apb(1'b1, 12'h004, 32'h3);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[0], 1'b0);
            tx_count <= tx_thr[c][4:0];
            repeat (2) @(posedge ref_clk);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[0], 1'b1);
            // Count register shows the transmit fill the bench drives, receive side empty
            apb(1'b0, 12'h00c, 32'h0);
            chk(rd, 32'(tx_thr[c]) << 8);
            chk(err, 1'b0);
        end
        // Transmit flag is set now: mask it on and off
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        apb(1'b1, 12'h008, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // A second reset in mid-run must clear a loaded control register again
        apb(1'b1, 12'h000, 32'h0738);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        chk(rts_n, 1'b0);
        finish_test;
    end

    // Watchdog well beyond the expected run of about 1150 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test;
    end
endmodule // testbench
